/* rtl/inverter_serial_request_sequencer.sv */
// master-side sequencer: control write to each slave in turn, then status read from each
`timescale 1ns/1ps
`default_nettype none

module inverter_serial_request_sequencer #(
   parameter int unsigned SEND_WAIT_CYC   = seq_pkg::SEND_WAIT_CYC,
   parameter int unsigned SEND_DONE_CYC   = seq_pkg::SUPERVISE_CYC,
   parameter int unsigned REPLY_START_CYC = seq_pkg::SUPERVISE_CYC,
   parameter int unsigned RECV_DONE_CYC   = seq_pkg::SUPERVISE_CYC
)(
   input  wire logic                      mclk,
   input  wire logic                      reset_n,
   input  wire logic                      start,
   input  wire logic                      err_clear,
   input  wire seq_pkg::seq_cfg_type      cfg,
   input  wire seq_pkg::slave_fields_type slave,
   input  wire logic                      tx_ready,
   input  wire logic                      rx_valid,
   input  wire logic [7:0]                rx_byte,
   output logic [7:0]                     slave_index,
   output logic [7:0]                     tx_byte,
   output logic                           tx_valid,
   output seq_pkg::store_type             store,
   output logic                           busy,
   output logic                           seq_done,
   output logic                           comm_error
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_STEP = 3'b001,
      ST_WAIT = 3'b010,
      ST_SEND = 3'b011,
      ST_RESP = 3'b100,
      ST_RECV = 3'b101
   } state_type;

   state_type          state_q;
   logic               step_q;
   logic [7:0]         n_q;
   logic [3:0]         fail_cnt_q;
   logic [31:0]        timer_q;
   logic [3:0]         tx_idx_q;
   logic [15:0]        tx_crc_q;
   logic [7:0]         tx_byte_q;
   logic               tx_valid_q;
   logic               bcast_q;
   logic [3:0]         rx_idx_q;
   logic [15:0]        rx_crc_q;
   logic               bad_q;
   logic [15:0]        rx_data_q;
   seq_pkg::store_type store_q;
   logic               busy_q;
   logic               done_q;
   logic               err_q;

   // decoding
   logic [7:0]  cur_func;
   logic [3:0]  plen;
   logic [3:0]  rlen;
   logic [3:0]  retry_lim;
   logic [7:0]  req_byte;
   logic [7:0]  cur_byte;
   logic [15:0] rx_crc_nx;
   logic        timeout;
   logic        tx_free;
   logic        tx_end;
   logic        rx_take;
   logic        rx_last;
   logic        mism;
   logic        rx_ok;
   logic        step_ok;
   logic        fail_now;
   logic        give_up;
   logic        step_over;

   assign cur_func  = step_q ? seq_pkg::FUNC_READ : seq_pkg::FUNC_WRITE;
   assign plen      = step_q ? seq_pkg::RD_REQ_LEN : seq_pkg::WR_REQ_LEN;
   assign rlen      = step_q ? seq_pkg::RD_REPLY_LEN
                             : seq_pkg::WR_REPLY_LEN;
   assign retry_lim = (cfg.retries > seq_pkg::MAX_RETRY) ?
                      seq_pkg::MAX_RETRY : cfg.retries;
   assign timeout   = (timer_q == 32'h0000_0000);
   assign step_over = (n_q == cfg.repeat_n);

   // request bytes; the frame has no header or terminator
   always_comb
   begin
      unique case (tx_idx_q)
         4'h0: req_byte = slave.addr;
         4'h1: req_byte = cur_func;
         4'h2: req_byte = step_q ? seq_pkg::RD_REG[15:8]
                                 : seq_pkg::WR_START[15:8];
         4'h3: req_byte = step_q ? seq_pkg::RD_REG[7:0]
                                 : seq_pkg::WR_START[7:0];
         4'h4: req_byte = step_q ? seq_pkg::RD_COUNT[15:8]
                                 : seq_pkg::WR_COUNT[15:8];
         4'h5: req_byte = step_q ? seq_pkg::RD_COUNT[7:0]
                                 : seq_pkg::WR_COUNT[7:0];
         4'h6: req_byte = seq_pkg::WR_BYTES;
         4'h7: req_byte = slave.data[31:24];
         4'h8: req_byte = slave.data[23:16];
         4'h9: req_byte = slave.data[15:8];
         default: req_byte = slave.data[7:0];
      endcase
   end

   // crc trails the payload, low byte first
   assign cur_byte = (tx_idx_q < plen) ? req_byte :
                     (tx_idx_q == plen) ? tx_crc_q[7:0] : tx_crc_q[15:8];
   assign tx_free  = !tx_valid_q || tx_ready;
   assign tx_end   = (state_q == ST_SEND) && tx_free
                     && (tx_idx_q == 4'(plen + 4'h2));

   // reply checking: crc over the whole reply leaves zero
   assign rx_take   = ((state_q == ST_RESP) || (state_q == ST_RECV))
                      && rx_valid;
   assign rx_crc_nx = seq_pkg::crc_step(rx_crc_q, rx_byte);
   assign rx_last   = rx_take && (rx_idx_q == 4'(rlen - 4'h1));
   assign mism      = ((rx_idx_q == 4'h0) && (rx_byte != slave.addr))
                   || ((rx_idx_q == 4'h1) && (rx_byte != cur_func))
                   || (step_q && (rx_idx_q == 4'h2)
                       && (rx_byte != seq_pkg::RD_BYTES));
   assign rx_ok     = rx_last && !bad_q && !mism
                      && (rx_crc_nx == seq_pkg::CRC_RESIDUE);

   // broadcast ends with the last byte out
   assign step_ok   = (tx_end && bcast_q) || rx_ok;
   assign fail_now  = ((state_q == ST_SEND) && timeout && !tx_end)
                   || ((state_q == ST_RESP) && timeout && !rx_take)
                   || ((state_q == ST_RECV) && timeout && !rx_last)
                   || (rx_last && !rx_ok);
   // with a limit of three, the third failure gives up
   assign give_up   = fail_now && ({1'b0, fail_cnt_q} + 5'h01
                                   >= {1'b0, retry_lim});

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q    <= ST_IDLE;
         step_q     <= 1'b0;
         n_q        <= 8'h00;
         fail_cnt_q <= 4'h0;
         timer_q    <= 32'h0000_0000;
         bcast_q    <= 1'b0;
         done_q     <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (timer_q != 32'h0000_0000)
         begin
            timer_q <= timer_q - 32'h0000_0001;
         end
         unique case (state_q)
            ST_IDLE:
            begin
               if (start)
               begin
                  step_q     <= 1'b0;
                  n_q        <= 8'h00;
                  fail_cnt_q <= 4'h0;
                  state_q    <= ST_STEP;
               end
            end
            ST_STEP:
            begin
               if (!step_over)
               begin
                  // idle line before every frame
                  timer_q <= 32'(SEND_WAIT_CYC - 1);
                  state_q <= ST_WAIT;
               end
               else if (!step_q)
               begin
                  step_q <= 1'b1;
                  n_q    <= 8'h00;
               end
               else
               begin
                  done_q  <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_WAIT:
            begin
               if (timeout)
               begin
                  bcast_q <= (slave.addr == seq_pkg::BROADCAST_ADDR);
                  timer_q <= 32'(SEND_DONE_CYC - 1);
                  state_q <= ST_SEND;
               end
            end
            ST_SEND:
            begin
               if (tx_end && !bcast_q)
               begin
                  timer_q <= 32'(REPLY_START_CYC - 1);
                  state_q <= ST_RESP;
               end
            end
            ST_RESP:
            begin
               if (rx_take)
               begin
                  timer_q <= 32'(RECV_DONE_CYC - 1);
                  state_q <= ST_RECV;
               end
            end
            ST_RECV:
            begin
            end
            default: state_q <= ST_IDLE;
         endcase
         if (step_ok)
         begin
            n_q        <= n_q + 8'h01;
            fail_cnt_q <= 4'h0;
            state_q    <= ST_STEP;
         end
         else if (give_up)
         begin
            state_q <= ST_IDLE;
         end
         else if (fail_now)
         begin
            fail_cnt_q <= fail_cnt_q + 4'h1;
            timer_q    <= 32'(SEND_WAIT_CYC - 1);
            state_q    <= ST_WAIT;
         end
      end
   end

   // transmit side; a timeout drops the byte on offer
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_idx_q   <= 4'h0;
         tx_crc_q   <= seq_pkg::CRC_SEED;
         tx_byte_q  <= 8'h00;
         tx_valid_q <= 1'b0;
      end
      else if (state_q != ST_SEND || fail_now)
      begin
         tx_idx_q   <= 4'h0;
         tx_crc_q   <= seq_pkg::CRC_SEED;
         tx_valid_q <= 1'b0;
      end
      else if (tx_free)
      begin
         tx_valid_q <= (tx_idx_q < 4'(plen + 4'h2));
         if (tx_idx_q < 4'(plen + 4'h2))
         begin
            tx_byte_q <= cur_byte;
            tx_idx_q  <= tx_idx_q + 4'h1;
         end
         if (tx_idx_q < plen)
         begin
            tx_crc_q <= seq_pkg::crc_step(tx_crc_q, cur_byte);
         end
      end
   end

   // receive side; last two bytes before the crc are kept
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_idx_q  <= 4'h0;
         rx_crc_q  <= seq_pkg::CRC_SEED;
         bad_q     <= 1'b0;
         rx_data_q <= 16'h0000;
      end
      else if (state_q == ST_SEND)
      begin
         rx_idx_q <= 4'h0;
         rx_crc_q <= seq_pkg::CRC_SEED;
         bad_q    <= 1'b0;
      end
      else if (rx_take)
      begin
         rx_idx_q <= rx_idx_q + 4'h1;
         rx_crc_q <= rx_crc_nx;
         bad_q    <= bad_q || mism;
         if (rx_idx_q == 4'(rlen - 4'h4))
         begin
            rx_data_q[15:8] <= rx_byte;
         end
         if (rx_idx_q == 4'(rlen - 4'h3))
         begin
            rx_data_q[7:0] <= rx_byte;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         store_q <= '0;
         busy_q  <= 1'b0;
         err_q   <= 1'b0;
      end
      else
      begin
         store_q.valid <= rx_ok;
         if (rx_ok)
         begin
            store_q.step  <= step_q;
            store_q.index <= n_q;
            store_q.data  <= rx_data_q;
         end
         busy_q <= (state_q != ST_IDLE) || start;
         // set wins over clear
         err_q  <= give_up || (err_q && !err_clear);
      end
   end

   assign slave_index = n_q;
   assign tx_byte     = tx_byte_q;
   assign tx_valid    = tx_valid_q;
   assign store       = store_q;
   assign busy        = busy_q;
   assign seq_done    = done_q;
   assign comm_error  = err_q;

   // checks
   logic [31:0] idle_run_q;

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         idle_run_q <= 32'h0000_0000;
      end
      else
      begin
         idle_run_q <= (state_q == ST_WAIT) ? idle_run_q + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_wait_silent: assert property (
      state_q == ST_WAIT |-> !tx_valid_q)
      else $error("byte offered during send wait");
   a_wait_length: assert property (
      state_q == ST_WAIT && $past(state_q) == ST_WAIT
      && state_q == ST_WAIT ##1 state_q == ST_SEND
      |-> $past(idle_run_q) >= 32'(SEND_WAIT_CYC - 1))
      else $error("send wait cut short");
   a_first_addr: assert property (
      state_q == ST_SEND && tx_valid_q && tx_idx_q == 4'h1
      |-> tx_byte_q == slave.addr)
      else $error("first byte is not slave address");
   a_func_byte: assert property (
      state_q == ST_SEND && tx_valid_q && tx_idx_q == 4'h2
      |-> tx_byte_q == (step_q ? 8'h03 : 8'h10))
      else $error("wrong function byte");
   a_reply_timeout: assert property (
      state_q == ST_RESP && timeout && !rx_valid
      |=> state_q == ST_WAIT || state_q == ST_IDLE)
      else $error("reply timeout not acted on");
   a_abort_flag: assert property (
      give_up |=> comm_error && state_q == ST_IDLE)
      else $error("abort did not flag error");
   a_error_sticky: assert property (
      comm_error && !err_clear && !give_up |=> comm_error)
      else $error("error flag lost");
   a_retry_bound: assert property (
      fail_cnt_q <= 4'h9)
      else $error("failure count past nine");
   a_counter_clear: assert property (
      $changed(step_q) |-> n_q == 8'h00)
      else $error("repeat counter not cleared");
   a_store_reply: assert property (
      rx_ok |=> store.valid && store.index == $past(n_q))
      else $error("good reply not stored");
   a_bcast_quiet: assert property (
      state_q == ST_RESP |-> !bcast_q)
      else $error("broadcast waits for reply");

   c_seq_end: cover property (seq_done);
   c_retry: cover property (fail_now && !give_up);
   c_abort: cover property ($rose(comm_error));
   c_status: cover property (store.valid && store.step);

endmodule

`default_nettype wire

/* rtl/seq_pkg.sv */
// constants, types and crc helper for the inverter request sequencer
package seq_pkg;

   localparam int unsigned CLK_KHZ        = 25000;
   localparam int unsigned SEND_WAIT_US   = 20000;
   localparam int unsigned SUPERVISE_MS   = 500;
   // least time: round up to whole cycles
   localparam int unsigned SEND_WAIT_CYC  =
      (SEND_WAIT_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned SUPERVISE_CYC  = SUPERVISE_MS * CLK_KHZ;

   localparam logic [15:0] CRC_SEED       = 16'hFFFF;
   localparam logic [15:0] CRC_POLY       = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE    = 16'h0000;

   localparam logic [7:0]  FUNC_WRITE     = 8'h10;
   localparam logic [7:0]  FUNC_READ      = 8'h03;
   localparam logic [15:0] WR_START       = 16'h0001;
   localparam logic [15:0] WR_COUNT       = 16'h0002;
   localparam logic [7:0]  WR_BYTES       = 8'h04;
   localparam logic [15:0] RD_REG         = 16'h002C;
   localparam logic [15:0] RD_COUNT       = 16'h0001;
   localparam logic [7:0]  RD_BYTES       = 8'h02;
   localparam logic [7:0]  BROADCAST_ADDR = 8'h00;

   // payload lengths before the two crc bytes, and whole reply lengths
   localparam logic [3:0]  WR_REQ_LEN     = 4'hB;
   localparam logic [3:0]  RD_REQ_LEN     = 4'h6;
   localparam logic [3:0]  WR_REPLY_LEN   = 4'h8;
   localparam logic [3:0]  RD_REPLY_LEN   = 4'h7;
   localparam logic [3:0]  MAX_RETRY      = 4'h9;

   typedef struct packed {
      logic [7:0] repeat_n;
      logic [3:0] retries;
   } seq_cfg_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
   } slave_fields_type;

   typedef struct packed {
      logic        valid;
      logic        step;
      logic [7:0]  index;
      logic [15:0] data;
   } store_type;

   function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                            input logic [7:0]  b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

endpackage

/* tb/inverter_model.sv */
// behavioural inverter on the byte link: takes requests, answers them
`timescale 1ns/1ps
`default_nettype none

module inverter_model (
   input  wire logic        mclk,
   input  wire logic [7:0]  tx_byte,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic             rx_valid,
   output logic [7:0]       rx_byte,
   input  wire logic [2:0]  mode,
   input  wire logic [1:0]  pace,
   input  wire logic [15:0] status
);
   // mode 0 good, 1 silent, 2 bad crc, 3 cut short
   // mode 4 wrong address, 5 wrong function, both with a good crc
   // pace 0 always ready, 1 every other cycle, 2 never
   logic [7:0] q[$];
   logic [7:0] wr_f[$];
   logic [7:0] rd_f[$];

   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i])
      begin
         c ^= {8'h00, b[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction

   task automatic answer(input logic [7:0] f[$]);
      logic [7:0]  r[$];
      logic [15:0] c;
      if (f[1] == 8'h10)
         r = f[0:5];
      else
         r = {f[0], 8'h03, 8'h02, status[15:8], status[7:0]};
      if (mode == 3'h4)
         r[0] = ~r[0];
      if (mode == 3'h5)
         r[1] = ~r[1];
      c = crc16(r);
      r.push_back(mode == 3'h2 ? ~c[7:0] : c[7:0]);
      r.push_back(c[15:8]);
      if (mode == 3'h3)
         r = r[0:2];
      repeat (5) @(posedge mclk);
      foreach (r[i])
      begin
         rx_valid <= 1'b1;
         rx_byte  <= r[i];
         @(posedge mclk);
         // released line: never leave the old byte standing
         rx_valid <= 1'b0;
         rx_byte  <= ~r[i];
         @(posedge mclk);
      end
   endtask

   initial
   begin
      tx_ready = 1'b1;
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
      forever
      begin
         @(posedge mclk);
         if (tx_valid && tx_ready)
         begin
            q.push_back(tx_byte);
            if (q.size() > 1 && q.size() == (q[1] == 8'h10 ? 13 : 8))
            begin
               if (q[1] == 8'h10)
                  wr_f = q;
               else
                  rd_f = q;
               if (q[0] != 8'h00 && mode != 3'h1)
                  answer(q);
               q = {};
            end
         end
         tx_ready <= (pace == 2'h0) || (pace == 2'h1 && !tx_ready);
      end
   end
endmodule

`default_nettype wire

/* tb/test_inverter_serial_request_sequencer.sv */
// self-checking bench for the inverter request sequencer
`timescale 1ns/1ps
`default_nettype none

module test_inverter_serial_request_sequencer;
   localparam int SW = 20;
   localparam int TO = 200;
   logic                      mclk, reset_n, start, err_clear, bcast;
   logic                      tx_ready, rx_valid, tx_valid, tx_prev;
   logic                      busy, seq_done, comm_error;
   logic [7:0]                rx_byte, tx_byte, slave_index;
   logic [2:0]                mode;
   logic [1:0]                pace;
   seq_pkg::seq_cfg_type      cfg;
   seq_pkg::slave_fields_type slave;
   seq_pkg::store_type        store;
   seq_pkg::store_type        st_q[$];
   int                        n_fail, check_count, n_done, n_offer, gap;
   int                        cyc, last_at, spacing;

   always #20 mclk = ~mclk;
   always_comb
      slave = '{addr: bcast ? 8'h00 : slave_index + 8'h01,
                data: {slave_index, 24'hA55A3C}};

   inverter_serial_request_sequencer #(.SEND_WAIT_CYC(SW),
      .SEND_DONE_CYC(TO), .REPLY_START_CYC(TO), .RECV_DONE_CYC(TO))
   i_inverter_serial_request_sequencer (.mclk(mclk), .reset_n(reset_n),
      .start(start), .err_clear(err_clear), .cfg(cfg), .slave(slave),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .slave_index(slave_index), .tx_byte(tx_byte), .tx_valid(tx_valid),
      .store(store), .busy(busy), .seq_done(seq_done),
      .comm_error(comm_error));

   inverter_model i_inverter_model (.mclk(mclk), .tx_byte(tx_byte),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .mode(mode), .pace(pace), .status(16'hC3A5));

   task automatic check(input logic [15:0] seen, input logic [15:0] want,
                        input string what);
      check_count++;
      if (seen !== want)
      begin
         n_fail++;
         $display("BAD %0t %s: %h want %h", $time, what, seen, want);
      end
   endtask

   // link monitor: replies, completions and idle time before each offer
   always @(posedge mclk)
   begin
      cyc++;
      if (store.valid === 1'b1)
         st_q.push_back(store);
      if (seq_done === 1'b1)
         n_done++;
      if (tx_valid === 1'b1 && tx_prev !== 1'b1)
      begin
         n_offer++;
         spacing = cyc - last_at;
         last_at = cyc;
         check(16'(gap >= SW - 1), 16'h1, "send wait");
      end
      gap = (rx_valid || (tx_valid && tx_ready) || !busy) ? 0 : gap + 1;
      tx_prev = tx_valid;
   end

   task automatic run(input logic [7:0] n, input logic [3:0] r);
      st_q = {};
      n_done = 0;
      n_offer = 0;
      cfg <= '{repeat_n: n, retries: r};
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 30000 && busy === 1'b1; i++)
         @(posedge mclk);
      repeat (2) @(posedge mclk);
      check(16'(busy), 16'h0, "hang");
   endtask

   task automatic t_normal(input logic [1:0] p);
      logic [7:0] e[$];
      pace <= p;
      mode <= 3'h0;
      run(8'h03, 4'h3);
      check(16'(n_offer), 16'h6, "frames");
      check(16'(n_done), 16'h1, "done");
      check(16'(comm_error), 16'h0, "error");
      check(16'(st_q.size()), 16'h6, "stores");
      foreach (st_q[i])
      begin
         check({st_q[i].step, 7'h00, st_q[i].index},
               {1'(i > 2), 7'h00, 8'(i % 3)}, "order");
         check(st_q[i].data, i > 2 ? 16'hC3A5 : 16'h0002, "data");
      end
      e = {8'h03, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h02,
           8'hA5, 8'h5A, 8'h3C};
      foreach (e[i])
         check(i_inverter_model.wr_f[i], e[i], "write frame");
      check(i_inverter_model.crc16(i_inverter_model.wr_f), 16'h0, "wcrc");
      e = {8'h03, 8'h03, 8'h00, 8'h2C, 8'h00, 8'h01};
      foreach (e[i])
         check(i_inverter_model.rd_f[i], e[i], "read frame");
      check(i_inverter_model.crc16(i_inverter_model.rd_f), 16'h0, "rcrc");
      $display("t_normal done");
   endtask

   task automatic t_bcast;
      bcast <= 1'b1;
      run(8'h01, 4'h3);
      check(16'(n_offer), 16'h2, "bcast frames");
      check(16'(st_q.size()), 16'h0, "bcast stores");
      check(16'(n_done), 16'h1, "bcast done");
      bcast <= 1'b0;
      run(8'h00, 4'h3);
      check(16'(n_offer), 16'h0, "zero frames");
      check(16'(n_done), 16'h1, "zero done");
      $display("t_bcast done");
   endtask

   task automatic t_fail(input logic [2:0] m, input logic [1:0] p,
                         input logic [3:0] r, input logic [15:0] want,
                         input logic [15:0] space);
      mode <= m;
      pace <= p;
      run(8'h02, r);
      check(16'(n_offer), want, "attempts");
      if (want > 16'h0001)
         check(16'(spacing), space, "retry spacing");
      check(16'(comm_error), 16'h1, "abort flag");
      check(16'(n_done), 16'h0, "no end");
      check(16'(st_q.size()), 16'h0, "no store");
      repeat (50) @(posedge mclk);
      check(16'(comm_error), 16'h1, "sticky");
      err_clear <= 1'b1;
      @(posedge mclk);
      err_clear <= 1'b0;
      repeat (2) @(posedge mclk);
      check(16'(comm_error), 16'h0, "cleared");
      $display("t_fail done");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #(40 * 60000);
      n_fail++;
      $display("BAD %0t watchdog", $time);
      test_done;
   end

   initial
   begin
      mclk = 1'b0;
      reset_n = 1'b0;
      start = 1'b0;
      err_clear = 1'b0;
      bcast = 1'b0;
      mode = 3'h0;
      pace = 2'h0;
      cfg = '0;
      n_fail = 0;
      check_count = 0;
      gap = 0;
      cyc = 0;
      last_at = 0;
      spacing = 0;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      #1;
      check({busy, seq_done, comm_error, tx_valid, store.valid}, 16'h0,
            "reset");
      @(posedge mclk);
      t_normal(2'h0);
      t_normal(2'h1);
      t_bcast;
      // spacing: 14 cycles of frame, then model reply (6 to first
      // byte, 20 to last) or a supervision timeout, then send wait
      t_fail(3'h1, 2'h0, 4'h3, 16'h3, 16'(14 + TO + SW));
      t_fail(3'h1, 2'h0, 4'h0, 16'h1, 16'h0);
      t_fail(3'h1, 2'h0, 4'hC, 16'h9, 16'(14 + TO + SW));
      t_fail(3'h2, 2'h0, 4'h2, 16'h2, 16'(34 + SW));
      t_fail(3'h3, 2'h1, 4'h1, 16'h1, 16'h0);
      t_fail(3'h3, 2'h0, 4'h2, 16'h2, 16'(20 + TO + SW));
      t_fail(3'h4, 2'h0, 4'h3, 16'h3, 16'(34 + SW));
      t_fail(3'h5, 2'h0, 4'h1, 16'h1, 16'h0);
      t_fail(3'h0, 2'h2, 4'h2, 16'h2, 16'(TO + SW));
      test_done;
   end
endmodule

`default_nettype wire
